// File: design/pdm_top.v
// pulse density modulator with its APB register file and pin 2 output mux
`timescale 1ns/1ns
`include "pdm_defs.vh"

module pdm_top
(
  input wire CLK_SYS,
  input wire RST,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PWDATA,
  input wire [3:0] PSTRB,
  output wire [31:0] PRDATA,
  output wire PREADY,
  output wire PSLVERR,
  input wire GPIO_P22_DATA,
  input wire PIN_P22_I,
  output wire PIN_P22_O,
  output wire PIN_P22_OE,
  output wire P22_IN,
  output wire [7:0] PORT2_DIR,
  output wire [7:0] MAIN_CLOCK_SEL,
  output wire PDM_A_OUT,
  output wire PDM_B_OUT
);

  // register file
  reg [7:0] main_clock_q;
  reg [7:0] port2_direction_q;
  reg [7:0] port2_output_mux_q;
  reg [7:0] density_word_a_high_q;
  reg [7:0] density_word_a_low_q;
  reg [7:0] density_word_b_high_q;
  reg [7:0] density_word_b_low_q;
  reg [7:0] modulator_control_q;

  // bus answer registers
  reg [7:0] rdata_q;
  reg [7:0] rdata_d;
  reg slverr_q;
  reg slverr_d;

  // modulator state
  reg [`PDM_CNT_W-1:0] cnt_q;
  reg [`PDM_CNT_W-1:0] cnt_d;
  reg out_a_q;
  reg out_b_q;
  reg pin_o_q;
  reg pin_oe_q;
  reg pin_in_q;

  wire setup_phase;
  wire wr_access;
  wire lane0;
  wire modulator_enable;
  wire [2:0] modulator_clock_divisor;
  wire pin2_modulator_route;
  wire modulator_clock;
  wire [15:0] density_word_a;
  wire [15:0] density_word_b;
  wire [15:0] weighted;
  wire [15:0] include_a;
  wire [15:0] include_b;
  wire mix_a;
  wire mix_b;
  wire pin_route;

  // bus phases: data prepared in setup, write taken in access
  assign setup_phase = PSEL & ~PENABLE;
  assign wr_access = PSEL & PENABLE & PWRITE;
  assign lane0 = PSTRB[0];

  // zero wait state slave; answer data registered in setup
  assign PREADY = 1'b1;
  assign PRDATA = {24'h000000, rdata_q};
  assign PSLVERR = slverr_q;

  // control fields
  assign modulator_enable = modulator_control_q[`PDM_CTL_EN_BIT];
  assign modulator_clock_divisor = modulator_control_q[`PDM_CTL_DIV_MSB:`PDM_CTL_DIV_LSB];
  assign pin2_modulator_route = port2_output_mux_q[`PDM_MUX_ROUTE_BIT];

  // full density words from their byte halves
  assign density_word_a = {density_word_a_high_q, density_word_a_low_q};
  assign density_word_b = {density_word_b_high_q, density_word_b_low_q};

  // read data and error decode for the coming access phase
  always @*
  begin
    rdata_d = rdata_q;
    slverr_d = 1'b0;
    if (setup_phase)
    begin
      rdata_d = 8'h00;
      if (PADDR == `PDM_ADDR_MAIN_CLK)
      begin
        rdata_d = main_clock_q;
      end
      else if (PADDR == `PDM_ADDR_P2_DIR)
      begin
        rdata_d = port2_direction_q;
      end
      else if (PADDR == `PDM_ADDR_P2_MUX)
      begin
        rdata_d = port2_output_mux_q;
      end
      else if (PADDR == `PDM_ADDR_DWA_HIGH)
      begin
        rdata_d = density_word_a_high_q;
      end
      else if (PADDR == `PDM_ADDR_DWA_LOW)
      begin
        rdata_d = density_word_a_low_q;
      end
      else if (PADDR == `PDM_ADDR_DWB_HIGH)
      begin
        rdata_d = density_word_b_high_q;
      end
      else if (PADDR == `PDM_ADDR_DWB_LOW)
      begin
        rdata_d = density_word_b_low_q;
      end
      else if (PADDR == `PDM_ADDR_CONTROL)
      begin
        rdata_d = modulator_control_q;
      end
      else
      begin
        slverr_d = 1'b1; // unmapped address
      end
    end
  end

  // bus answer registers
  always @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      rdata_q <= `PDM_RST_BYTE;
      slverr_q <= 1'b0;
    end
    else
    begin
      rdata_q <= rdata_d;
      slverr_q <= slverr_d;
    end
  end

  // register writes, taken at the access edge on byte lane 0
  always @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      main_clock_q <= `PDM_RST_BYTE;
      port2_direction_q <= `PDM_RST_BYTE;
      port2_output_mux_q <= `PDM_RST_BYTE;
      density_word_a_high_q <= `PDM_RST_BYTE;
      density_word_a_low_q <= `PDM_RST_BYTE;
      density_word_b_high_q <= `PDM_RST_BYTE;
      density_word_b_low_q <= `PDM_RST_BYTE;
      modulator_control_q <= `PDM_RST_BYTE;
    end
    else if (wr_access && lane0)
    begin
      if (PADDR == `PDM_ADDR_MAIN_CLK)
      begin
        main_clock_q <= PWDATA[7:0];
      end
      else if (PADDR == `PDM_ADDR_P2_DIR)
      begin
        port2_direction_q <= PWDATA[7:0];
      end
      else if (PADDR == `PDM_ADDR_P2_MUX)
      begin
        port2_output_mux_q <= PWDATA[7:0] & `PDM_MUX_WMASK;
      end
      else if (PADDR == `PDM_ADDR_DWA_HIGH)
      begin
        density_word_a_high_q <= PWDATA[7:0];
      end
      else if (PADDR == `PDM_ADDR_DWA_LOW)
      begin
        density_word_a_low_q <= PWDATA[7:0];
      end
      else if (PADDR == `PDM_ADDR_DWB_HIGH)
      begin
        density_word_b_high_q <= PWDATA[7:0];
      end
      else if (PADDR == `PDM_ADDR_DWB_LOW)
      begin
        density_word_b_low_q <= PWDATA[7:0];
      end
      else if (PADDR == `PDM_ADDR_CONTROL)
      begin
        modulator_control_q <= PWDATA[7:0] & `PDM_CTL_WMASK;
      end
    end
  end

  // modulator clock enable, divided from the main clock
  pdm_clkdiv u_clkdiv
  (
    .clk(CLK_SYS),
    .rst(RST),
    .run(modulator_enable),
    .sel(modulator_clock_divisor),
    .tick(modulator_clock)
  );

  // free running weight counter, held at zero while disabled
  always @*
  begin
    if (!modulator_enable)
    begin
      cnt_d = `PDM_RST_WORD;
    end
    else if (modulator_clock)
    begin
      cnt_d = cnt_q + 16'h0001;
    end
    else
    begin
      cnt_d = cnt_q;
    end
  end

  // counter register
  always @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      cnt_q <= `PDM_RST_WORD;
    end
    else
    begin
      cnt_q <= cnt_d;
    end
  end

  // signal n: counter bit 15-n set with all lower bits clear
  genvar n;
  generate
    for (n = 0; n < 16; n = n + 1)
    begin : g_weight
      localparam [15:0] LOW_MASK = (16'h0001 << (15 - n)) - 16'h0001;
      // high once per 2^(16-n) counts, never with another signal
      assign weighted[n] = cnt_q[15 - n] & ((cnt_q & LOW_MASK) == 16'h0000);
    end
  endgenerate

  // a cleared word bit includes its signal
  assign include_a = ~density_word_a;
  assign include_b = ~density_word_b;

  // combined streams and the pin route condition
  assign mix_a = |(weighted & include_a);
  assign mix_b = |(weighted & include_b);
  assign pin_route = modulator_enable & pin2_modulator_route;

  // combined outputs, low while disabled
  always @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      out_a_q <= 1'b0;
      out_b_q <= 1'b0;
    end
    else if (!modulator_enable)
    begin
      out_a_q <= 1'b0;
      out_b_q <= 1'b0;
    end
    else
    begin
      out_a_q <= mix_a;
      out_b_q <= mix_b;
    end
  end

  assign PDM_A_OUT = out_a_q;
  assign PDM_B_OUT = out_b_q;

  // pin 2: modulator when enabled and routed, otherwise port latch
  always @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      pin_o_q <= 1'b0;
      pin_oe_q <= 1'b0;
    end
    else
    begin
      if (pin_route)
      begin
        pin_o_q <= mix_a;
      end
      else
      begin
        pin_o_q <= GPIO_P22_DATA;
      end
      pin_oe_q <= port2_direction_q[`PDM_PIN_BIT];
    end
  end

  // pin input register, read back as the port level
  always @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      pin_in_q <= 1'b0;
    end
    else
    begin
      pin_in_q <= PIN_P22_I;
    end
  end

  assign PIN_P22_O = pin_o_q;
  assign PIN_P22_OE = pin_oe_q;
  assign P22_IN = pin_in_q;
  assign PORT2_DIR = port2_direction_q;
  assign MAIN_CLOCK_SEL = main_clock_q;

endmodule

// File: pkg/pdm_defs.vh
// register map, field positions and reset values of the pulse density modulator
`ifndef PDM_DEFS_VH
`define PDM_DEFS_VH

// register indices; byte address on the bus is four times the index
`define PDM_IDX_MAIN_CLK   8'h14
`define PDM_IDX_P2_DIR     8'h25
`define PDM_IDX_P2_MUX     8'h27
`define PDM_IDX_DWA_HIGH   8'h30
`define PDM_IDX_DWA_LOW    8'h31
`define PDM_IDX_DWB_HIGH   8'h32
`define PDM_IDX_DWB_LOW    8'h33
`define PDM_IDX_CONTROL    8'h36

// byte addresses on the bus
`define PDM_ADDR_MAIN_CLK  8'h50
`define PDM_ADDR_P2_DIR    8'h94
`define PDM_ADDR_P2_MUX    8'h9C
`define PDM_ADDR_DWA_HIGH  8'hC0
`define PDM_ADDR_DWA_LOW   8'hC4
`define PDM_ADDR_DWB_HIGH  8'hC8
`define PDM_ADDR_DWB_LOW   8'hCC
`define PDM_ADDR_CONTROL   8'hD8

// control register fields
`define PDM_CTL_EN_BIT     4
`define PDM_CTL_DIV_MSB    2
`define PDM_CTL_DIV_LSB    0
`define PDM_CTL_WMASK      8'h17

// port 2 mux: modulator route to pin 2
`define PDM_MUX_ROUTE_BIT  4
`define PDM_MUX_WMASK      8'h10

// port 2 direction bit of the modulator pin
`define PDM_PIN_BIT        2

// reset values
`define PDM_RST_BYTE       8'h00
`define PDM_RST_WORD       16'h0000

// divider and counter sizes
`define PDM_DIV_W          7
`define PDM_CNT_W          16

`endif

// File: design/pdm_clkdiv.v
// prescaler making the modulator clock enable from the main clock
`timescale 1ns/1ns
`include "pdm_defs.vh"

module pdm_clkdiv
(
  input wire clk,
  input wire rst,
  input wire run,
  input wire [2:0] sel,
  output wire tick
);

  reg [`PDM_DIV_W-1:0] cnt_q;
  reg [`PDM_DIV_W-1:0] cnt_d;
  wire [`PDM_DIV_W-1:0] low_mask;

  // code k keeps k low bits of the count; all ones every 2^k cycles
  assign low_mask = ~({`PDM_DIV_W{1'b1}} << sel);
  assign tick = run & ((cnt_q & low_mask) == low_mask);

  // free count while running, parked at zero when stopped
  always @*
  begin
    if (run)
    begin
      cnt_d = cnt_q + 7'h01;
    end
    else
    begin
      cnt_d = 7'h00;
    end
  end

  // count register
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= 7'h00;
    end
    else
    begin
      cnt_q <= cnt_d;
    end
  end

endmodule

// File: tb/pdm_top_chk.sv
// port-level assertion checker for the pulse density modulator
`timescale 1ns/1ns
`include "pdm_defs.vh"
module pdm_top_chk
(
  input wire CLK_SYS,
  input wire RST,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PWDATA,
  input wire [3:0] PSTRB,
  input wire [31:0] PRDATA,
  input wire PREADY,
  input wire PSLVERR,
  input wire PIN_P22_OE,
  input wire [7:0] PORT2_DIR,
  input wire [7:0] MAIN_CLOCK_SEL
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);
  // bus phase decode
  wire setup = PSEL & ~PENABLE;
  wire wr = PSEL & PENABLE & PWRITE & PSTRB[0];
  wire dir_wr = wr && PADDR == `PDM_ADDR_P2_DIR;
  wire map = PADDR inside {`PDM_ADDR_MAIN_CLK, `PDM_ADDR_P2_DIR, `PDM_ADDR_P2_MUX,
    `PDM_ADDR_DWA_HIGH, `PDM_ADDR_DWA_LOW, `PDM_ADDR_DWB_HIGH, `PDM_ADDR_DWB_LOW,
    `PDM_ADDR_CONTROL};
  property p_err; setup && !map |=> PSLVERR; endproperty
  a_err: assert property (p_err) else $error("no error on unmapped");
  property p_ok; setup && map |=> !PSLVERR; endproperty
  a_ok: assert property (p_ok) else $error("error on mapped");
  property p_top; PRDATA[31:8] == 24'h000000; endproperty
  a_top: assert property (p_top) else $error("upper read bits set");
  property p_zero; PSLVERR |-> PRDATA == 32'h00000000; endproperty
  a_zero: assert property (p_zero) else $error("data on error");
  property p_dir; dir_wr |=> PORT2_DIR == $past(PWDATA[7:0]); endproperty
  a_dir: assert property (p_dir) else $error("direction not written");
  property p_dst; !dir_wr |=> $stable(PORT2_DIR); endproperty
  a_dst: assert property (p_dst) else $error("direction changed");
  property p_mck; wr && PADDR == `PDM_ADDR_MAIN_CLK |=> MAIN_CLOCK_SEL == $past(PWDATA[7:0]);
  endproperty
  a_mck: assert property (p_mck) else $error("main clock not written");
  property p_rdd; setup && !PWRITE && PADDR == `PDM_ADDR_P2_DIR
    |=> PRDATA == {24'h000000, $past(PORT2_DIR)}; endproperty
  a_rdd: assert property (p_rdd) else $error("direction read wrong");
  property p_oe; $rose(PORT2_DIR[2]) |=> PIN_P22_OE ##1 PIN_P22_OE; endproperty
  a_oe: assert property (p_oe) else $error("pin not driven");
endmodule
bind pdm_top pdm_top_chk chk_u (.CLK_SYS, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
  .PSTRB, .PRDATA, .PREADY, .PSLVERR, .PIN_P22_OE, .PORT2_DIR, .MAIN_CLOCK_SEL);

// File: tb/pdm_top_tb.sv
// self-checking bench for the pulse density modulator
`timescale 1ns/1ns
`include "pdm_defs.vh"
module pdm_top_tb;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, gpio = 0, pin_i = 0;
  logic [7:0] pa = 8'h00;
  logic [31:0] pwd = 32'h00000000;
  logic [3:0] ps = 4'hF;
  wire [31:0] prd;
  wire rdy, err, pin_o, pin_oe, p_in, oa, ob;
  wire [7:0] dir, main_clock_select;
  logic [31:0] rd;
  logic re;
  logic [7:0] ha, hb;
  integer n_mismatch = 0, checked = 0, i, c, na, nb, np;
  logic [7:0] tab [8] = '{`PDM_ADDR_MAIN_CLK, `PDM_ADDR_P2_DIR, `PDM_ADDR_P2_MUX,
    `PDM_ADDR_DWA_HIGH, `PDM_ADDR_DWA_LOW, `PDM_ADDR_DWB_HIGH, `PDM_ADDR_DWB_LOW,
    `PDM_ADDR_CONTROL};
  // clock at 50 ns period
  always #25 clk = ~clk;
  pdm_top dut_u (.CLK_SYS(clk), .RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(pa), .PWDATA(pwd), .PSTRB(ps), .PRDATA(prd), .PREADY(rdy), .PSLVERR(err),
    .GPIO_P22_DATA(gpio), .PIN_P22_I(pin_i), .PIN_P22_O(pin_o), .PIN_P22_OE(pin_oe),
    .P22_IN(p_in), .PORT2_DIR(dir), .MAIN_CLOCK_SEL(main_clock_select), .PDM_A_OUT(oa), .PDM_B_OUT(ob));
  // one apb transfer, then an idle cycle
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    begin
      psel <= 1'b1;
      pwr <= w;
      pa <= a;
      pwd <= {24'h000000, d};
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (rdy !== 1'b1)
      begin
        @(posedge clk);
      end
      rd = prd;
      re = err;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
    end
  endtask
  // compare a design value
  task chk_bus(input logic [31:0] g, input logic [31:0] e);
    begin
      checked = checked + 1;
      if (g !== e)
      begin
        n_mismatch = n_mismatch + 1;
        $display("ERROR %0t value %h expected %h", $time, g, e);
      end
    end
  endtask
  // compare a counted figure
  task chk_num(input integer g, input integer e);
    begin
      checked = checked + 1;
      if (g !== e)
      begin
        n_mismatch = n_mismatch + 1;
        $display("ERROR %0t count %0d expected %0d", $time, g, e);
      end
    end
  endtask
  // read and compare, no error expected
  task rd_chk(input logic [7:0] a, input logic [7:0] e);
    begin
      bus(1'b0, a, 8'h00);
      chk_bus(rd, {24'h000000, e});
      chk_bus({31'h0, re}, 32'h0);
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  // watchdog, well past the expected run of about 66000 cycles
  initial
  begin
    #4500000;
    n_mismatch = n_mismatch + 1;
    give_verdict;
  end
  // test sequence
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (i = 0; i < 8; i = i + 1)
      rd_chk(tab[i], 8'h00);
    $display("test reset done");
    bus(1'b1, `PDM_ADDR_CONTROL, 8'hFF);
    rd_chk(`PDM_ADDR_CONTROL, 8'h17);
    bus(1'b1, `PDM_ADDR_P2_MUX, 8'hFF);
    rd_chk(`PDM_ADDR_P2_MUX, 8'h10);
    bus(1'b1, `PDM_ADDR_DWA_HIGH, 8'hA5);
    bus(1'b1, `PDM_ADDR_DWB_LOW, 8'h3C);
    rd_chk(`PDM_ADDR_DWA_HIGH, 8'hA5);
    rd_chk(`PDM_ADDR_DWB_LOW, 8'h3C);
    ps <= 4'h0;
    bus(1'b1, `PDM_ADDR_DWA_HIGH, 8'h00);
    ps <= 4'hF;
    bus(1'b1, 8'hC1, 8'h00);
    chk_bus({31'h0, re}, 32'h1);
    bus(1'b0, 8'h04, 8'h00);
    chk_bus({re, rd[30:0]}, 32'h80000000);
    rd_chk(`PDM_ADDR_DWA_HIGH, 8'hA5);
    bus(1'b1, `PDM_ADDR_MAIN_CLK, 8'h5A);
    rd_chk(`PDM_ADDR_MAIN_CLK, 8'h5A);
    bus(1'b1, `PDM_ADDR_P2_DIR, 8'h04);
    @(posedge clk);
    chk_bus({31'h0, pin_oe}, 32'h1);
    $display("test registers done");
    for (c = 0; c < 8; c = c + 1)
    begin
      ha = 8'hC0 | 8'(c * 9);
      hb = 8'hC0 | 8'(63 - c * 7);
      bus(1'b1, `PDM_ADDR_CONTROL, 8'h00);
      @(posedge clk);
      chk_bus({31'h0, oa}, 32'h0);
      bus(1'b1, `PDM_ADDR_DWA_HIGH, ha);
      bus(1'b1, `PDM_ADDR_DWA_LOW, 8'hFF);
      bus(1'b1, `PDM_ADDR_DWB_HIGH, hb);
      bus(1'b1, `PDM_ADDR_DWB_LOW, 8'hFF);
      bus(1'b1, `PDM_ADDR_CONTROL, 8'h10 | 8'(c));
      na = 0;
      nb = 0;
      np = 0;
      repeat (257 << c)
      begin
        @(posedge clk);
        na = na + oa;
        nb = nb + ob;
        np = np + pin_o;
      end
      chk_num(na, ((~ha) & 63) << c);
      chk_num(nb, ((~hb) & 63) << c);
      chk_num(np, ((~ha) & 63) << c);
      $display("test code %0d done", c);
    end
    bus(1'b1, `PDM_ADDR_CONTROL, 8'h00);
    gpio <= 1'b1;
    pin_i <= 1'b1;
    repeat (3) @(posedge clk);
    chk_bus({30'h0, pin_o, oa}, 32'h2);
    chk_bus({31'h0, p_in}, 32'h1);
    gpio <= 1'b0;
    bus(1'b1, `PDM_ADDR_DWA_HIGH, 8'h00);
    bus(1'b1, `PDM_ADDR_P2_MUX, 8'h00);
    bus(1'b1, `PDM_ADDR_CONTROL, 8'h10);
    na = 0;
    np = 0;
    repeat (8)
    begin
      @(posedge clk);
      na = na + oa;
      np = np + pin_o;
    end
    chk_num(na, 7);
    chk_num(np, 0);
    bus(1'b1, `PDM_ADDR_P2_DIR, 8'h00);
    repeat (2) @(posedge clk);
    chk_bus({31'h0, pin_oe}, 32'h0);
    $display("test pin done");
    give_verdict;
  end
endmodule
